// File: logic/cdm_params.svh
// constants for the cpu data memory map
`ifndef CDM_PARAMS_SVH
`define CDM_PARAMS_SVH
`define CDM_INTERNAL_DATA_RAM_DEPTH        256
`define CDM_EXTERNAL_DATA_RAM_DEPTH        256
`define CDM_PSTORE_DEPTH      8192
`define CDM_UPPER_BIT         7
`define CDM_BIT_AREA_BASE     8'h20
`define CDM_PSW_BANK_LO       3
`define CDM_PSW_BANK_HI       4
`define CDM_PSW_RESET         8'h00
`define CDM_CLK_PERIOD_NS     10
`define CDM_PSTORE_FMAX_MHZ   8
// minimum program store read period in ns, and in clock cycles rounded up
`define CDM_PSTORE_TMIN_NS    (1000 / `CDM_PSTORE_FMAX_MHZ)
`define CDM_PSTORE_CYCLES \
    ((`CDM_PSTORE_TMIN_NS + `CDM_CLK_PERIOD_NS - 1) / `CDM_CLK_PERIOD_NS)
`define CDM_EXTERNAL_DATA_RAM_WAIT         2
`endif

// File: logic/cdm_pkg.sv
// types for the cpu data memory map
`default_nettype none
package cdm_pkg;
    typedef logic [7:0] cdm_byte_t;
    typedef enum logic [1:0] {
        CDM_DIRECT,
        CDM_INDIRECT,
        CDM_BIT,
        CDM_REG
    } cdm_mode_e;
    typedef enum {
        CDM_X_IDLE,
        CDM_X_WAIT
    } cdm_xstate_e;
    typedef enum {
        CDM_P_IDLE,
        CDM_P_WAIT
    } cdm_pstate_e;
endpackage : cdm_pkg
`default_nettype wire

// File: logic/cdm_external_data_ram.sv
// external data ram with slow access
`timescale 1ns/10ps
`default_nettype none
`include "cdm_params.svh"
module cdm_external_data_ram (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       req,
    input  wire logic       we,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic [7:0]      rdata_q,
    output logic            ready_q
);
    logic [7:0]          mem [0:`CDM_EXTERNAL_DATA_RAM_DEPTH-1];
    cdm_pkg::cdm_xstate_e state_q;
    logic [1:0]          cnt_q;
    logic [7:0]          addr_q;
    logic [7:0]          wdata_q;
    logic                we_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= cdm_pkg::CDM_X_IDLE;
            cnt_q   <= 2'h0;
            ready_q <= 1'b0;
            addr_q  <= 8'h00;
            wdata_q <= 8'h00;
            we_q    <= 1'b0;
        end else begin
            ready_q <= 1'b0;
            case (state_q)
                cdm_pkg::CDM_X_IDLE: begin
                    if (req) begin
                        addr_q  <= addr;
                        wdata_q <= wdata;
                        we_q    <= we;
                        cnt_q   <= 2'(`CDM_EXTERNAL_DATA_RAM_WAIT);
                        state_q <= cdm_pkg::CDM_X_WAIT;
                    end
                end
                cdm_pkg::CDM_X_WAIT: begin
                    if (cnt_q == 2'h1) begin
                        ready_q <= 1'b1;
                        state_q <= cdm_pkg::CDM_X_IDLE;
                    end
                    cnt_q <= cnt_q - 2'h1;
                end
                default: state_q <= cdm_pkg::CDM_X_IDLE;
            endcase
        end
    end

    // storage, written or read at access end
    always_ff @(posedge clk) begin
        if (state_q == cdm_pkg::CDM_X_WAIT && cnt_q == 2'h1) begin
            if (we_q) begin
                mem[addr_q] <= wdata_q;
            end
            rdata_q <= mem[addr_q];
        end
    end
endmodule : cdm_external_data_ram
`default_nettype wire

// File: logic/cdm_data_memory.sv
// internal ram, work registers, bit area, external ram and program store port
`timescale 1ns/10ps
`default_nettype none
`include "cdm_params.svh"
module cdm_data_memory (
    input  wire logic        clk,
    input  wire logic        rstn,
    // internal access
    input  wire logic        internal_data_ram_req,
    input  wire logic        internal_data_ram_we,
    input  wire logic [1:0]  internal_data_ram_mode,
    input  wire logic [7:0]  internal_data_ram_addr,
    input  wire logic [7:0]  internal_data_ram_wdata,
    output logic [7:0]       internal_data_ram_rdata_q,
    output logic             internal_data_ram_valid_q,
    // special function register side
    output logic             sfr_req_q,
    output logic             sfr_we_q,
    output logic [7:0]       sfr_addr_q,
    output logic [7:0]       sfr_wdata_q,
    input  wire logic [7:0]  sfr_rdata,
    // status word bank bits
    input  wire logic        psw_we,
    input  wire logic [7:0]  psw_wdata,
    output logic [7:0]       program_status_word_q,
    // external data move
    input  wire logic        xmove_req,
    input  wire logic        xmove_we,
    input  wire logic [7:0]  xmove_wdata,
    input  wire logic        dptr_we,
    input  wire logic [15:0] dptr_wdata,
    output logic [15:0]      data_pointer_pair_q,
    output logic [7:0]       xmove_rdata_q,
    output logic             xmove_ready_q,
    // program store table read
    input  wire logic        pstore_req,
    input  wire logic [7:0]  pstore_data,
    output logic [12:0]      pstore_addr_q,
    output logic             pstore_rd_q,
    output logic [7:0]       pstore_rdata_q,
    output logic             pstore_ready_q
);
    // internal ram contents, never reset
    logic [7:0]            internal_data_ram [0:`CDM_INTERNAL_DATA_RAM_DEPTH-1];
    logic [7:0]            eff_addr;
    logic [2:0]            eff_bit;
    logic                  to_sfr;
    logic [7:0]            byte_now;
    // external ram answer
    logic [7:0]            xr_rdata;
    logic                  xr_ready;
    // program store pacing
    cdm_pkg::cdm_pstate_e  pst_q;
    logic [3:0]            pcnt_q;

    function automatic logic [7:0] reg_addr(input logic [7:0] program_status_word, input logic [2:0] n);
        reg_addr = {3'h0, program_status_word[`CDM_PSW_BANK_HI], program_status_word[`CDM_PSW_BANK_LO], n};
    endfunction : reg_addr

    function automatic logic [7:0] bit_byte(input logic [6:0] b);
        bit_byte = `CDM_BIT_AREA_BASE + {4'h0, b[6:3]};
    endfunction : bit_byte

    // address decode per mode
    always_comb begin
        eff_addr = internal_data_ram_addr;
        eff_bit  = 3'h0;
        to_sfr   = 1'b0;
        case (cdm_pkg::cdm_mode_e'(internal_data_ram_mode))
            // direct: upper half goes to sfr
            cdm_pkg::CDM_DIRECT: to_sfr = internal_data_ram_addr[`CDM_UPPER_BIT];
            cdm_pkg::CDM_INDIRECT: to_sfr = 1'b0;
            cdm_pkg::CDM_BIT: begin
                to_sfr   = internal_data_ram_addr[`CDM_UPPER_BIT];
                eff_addr = internal_data_ram_addr[`CDM_UPPER_BIT] ? internal_data_ram_addr
                                                     : bit_byte(internal_data_ram_addr[6:0]);
                eff_bit  = internal_data_ram_addr[2:0];
            end
            cdm_pkg::CDM_REG: eff_addr = reg_addr(program_status_word_q, internal_data_ram_addr[2:0]);
            // unreachable with a two bit mode
            default: to_sfr = 1'b0;
        endcase
        byte_now = internal_data_ram[eff_addr];
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            program_status_word_q <= `CDM_PSW_RESET;
        end else if (psw_we) begin
            program_status_word_q <= psw_wdata;
        end
    end

    // ram writes, single bit keeps its neighbours
    // bit writes merge into the current byte in one cycle,
    // so a read of the next cycle already sees the new bit
    always_ff @(posedge clk) begin
        if (internal_data_ram_req && internal_data_ram_we && !to_sfr) begin
            if (internal_data_ram_mode == 2'(cdm_pkg::CDM_BIT)) begin
                internal_data_ram[eff_addr] <= (byte_now & ~(8'h01 << eff_bit))
                                | ({7'h00, internal_data_ram_wdata[0]} << eff_bit);
            end else begin
                internal_data_ram[eff_addr] <= internal_data_ram_wdata;
            end
        end
    end

    // forward sfr accesses
    // address and data follow every cycle; only the strobes qualify them
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sfr_req_q   <= 1'b0;
            sfr_we_q    <= 1'b0;
            sfr_addr_q  <= 8'h00;
            sfr_wdata_q <= 8'h00;
        end else begin
            sfr_req_q   <= internal_data_ram_req && to_sfr;
            sfr_we_q    <= internal_data_ram_req && to_sfr && internal_data_ram_we;
            sfr_addr_q  <= eff_addr;
            sfr_wdata_q <= internal_data_ram_wdata;
        end
    end

    // read answer one cycle after request
    always_ff @(posedge clk) begin
        if (!rstn) begin
            internal_data_ram_valid_q <= 1'b0;
            internal_data_ram_rdata_q <= 8'h00;
        end else begin
            internal_data_ram_valid_q <= internal_data_ram_req && !internal_data_ram_we;
            // sfr-routed reads pulse valid but leave the data alone;
            // the sfr side answers on its own bus
            if (internal_data_ram_req && !internal_data_ram_we && !to_sfr) begin
                // bit read returns the bit in bit 0
                internal_data_ram_rdata_q <= (internal_data_ram_mode == 2'(cdm_pkg::CDM_BIT))
                              ? {7'h00, byte_now[eff_bit]} : byte_now;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            data_pointer_pair_q <= 16'h0000;
        end else if (dptr_we) begin
            data_pointer_pair_q <= dptr_wdata;
        end
    end

    // external ram behind data pointer low byte
    // the pointer high byte is ignored: the ram holds only 256 bytes
    cdm_external_data_ram u_external_data_ram (
        .clk     (clk),
        .rstn    (rstn),
        .req     (xmove_req),
        .we      (xmove_we),
        .addr    (data_pointer_pair_q[7:0]),
        .wdata   (xmove_wdata),
        .rdata_q (xr_rdata),
        .ready_q (xr_ready)
    );

    // external answer registered
    // the extra stage keeps the output straight from a flop here;
    // it adds one cycle to the external latency
    always_ff @(posedge clk) begin
        if (!rstn) begin
            xmove_ready_q <= 1'b0;
            xmove_rdata_q <= 8'h00;
        end else begin
            xmove_ready_q <= xr_ready;
            if (xr_ready) begin
                xmove_rdata_q <= xr_rdata;
            end
        end
    end

    // program store read paced to its maximum rate
    // the read strobe and address stand for the whole minimum period;
    // data is taken in the last cycle, then the store is free again;
    // requests while a read is in flight are dropped
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pst_q          <= cdm_pkg::CDM_P_IDLE;
            pcnt_q         <= 4'h0;
            pstore_addr_q  <= 13'h0000;
            pstore_rd_q    <= 1'b0;
            pstore_rdata_q <= 8'h00;
            pstore_ready_q <= 1'b0;
        end else begin
            pstore_ready_q <= 1'b0;
            case (pst_q)
                cdm_pkg::CDM_P_IDLE: begin
                    if (pstore_req) begin
                        pstore_addr_q <= data_pointer_pair_q[12:0];
                        pstore_rd_q   <= 1'b1;
                        pcnt_q        <= 4'(`CDM_PSTORE_CYCLES);
                        pst_q         <= cdm_pkg::CDM_P_WAIT;
                    end
                end
                cdm_pkg::CDM_P_WAIT: begin
                    pcnt_q <= pcnt_q - 4'h1;
                    if (pcnt_q == 4'h1) begin
                        pstore_rd_q    <= 1'b0;
                        pstore_rdata_q <= pstore_data;
                        pstore_ready_q <= 1'b1;
                        pst_q          <= cdm_pkg::CDM_P_IDLE;
                    end
                end
                default: pst_q <= cdm_pkg::CDM_P_IDLE;
            endcase
        end
    end
endmodule : cdm_data_memory
`default_nettype wire

// File: bench/cdm_store_model.sv
// program store model answering table reads
`timescale 1ns/10ps
`default_nettype none
module cdm_store_model (
    input  wire logic [12:0] addr,
    input  wire logic        rd,
    output logic      [7:0]  data
);
    // code byte from the read address
    // an idle bus shows the inverse, never a stale byte
    always_comb begin
        data = addr[7:0] ^ addr[12:5] ^ 8'hA5;
        if (!rd)
            data = ~data;
    end
endmodule : cdm_store_model
`default_nettype wire

// File: bench/cdm_properties.sv
// concurrent checks on the data memory ports
`timescale 1ns/10ps
`default_nettype none
module cdm_properties (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        internal_data_ram_req,
    input wire logic        internal_data_ram_we,
    input wire logic [1:0]  internal_data_ram_mode,
    input wire logic [7:0]  internal_data_ram_addr,
    input wire logic        internal_data_ram_valid_q,
    input wire logic        sfr_req_q,
    input wire logic [7:0]  sfr_addr_q,
    input wire logic        psw_we,
    input wire logic [7:0]  psw_wdata,
    input wire logic [7:0]  program_status_word_q,
    input wire logic        xmove_req,
    input wire logic        xmove_ready_q,
    input wire logic        dptr_we,
    input wire logic [15:0] dptr_wdata,
    input wire logic [15:0] data_pointer_pair_q,
    input wire logic        pstore_req,
    input wire logic [12:0] pstore_addr_q,
    input wire logic        pstore_rd_q,
    input wire logic        pstore_ready_q
);
    logic x_busy_q;
    logic p_busy_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // external move in flight
    always_ff @(posedge clk) begin
        if (!rstn || xmove_ready_q) x_busy_q <= 1'b0;
        else if (xmove_req) x_busy_q <= 1'b1;
    end
    // table read in flight
    always_ff @(posedge clk) begin
        if (!rstn || pstore_ready_q) p_busy_q <= 1'b0;
        else if (pstore_req) p_busy_q <= 1'b1;
    end
    sequence s_xwait; !xmove_ready_q [*3] ##1 xmove_ready_q; endsequence
    sequence s_pread;
        (pstore_rd_q && pstore_addr_q == data_pointer_pair_q[12:0]) [*8] ##6 pstore_ready_q;
    endsequence
    property p_rd_valid; internal_data_ram_req && !internal_data_ram_we |=> internal_data_ram_valid_q; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read gave no answer");
    property p_valid_cause; internal_data_ram_valid_q |-> $past(internal_data_ram_req) && !$past(internal_data_ram_we); endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("stray answer");
    property p_sfr_fwd;
        internal_data_ram_req && internal_data_ram_mode == 2'h0 && internal_data_ram_addr[7] |=> sfr_req_q && sfr_addr_q == $past(internal_data_ram_addr);
    endproperty
    a_sfr_fwd: assert property (p_sfr_fwd) else $error("direct upper not forwarded");
    property p_ind_ram; internal_data_ram_req && internal_data_ram_mode == 2'h1 |=> !sfr_req_q; endproperty
    a_ind_ram: assert property (p_ind_ram) else $error("indirect reached sfr");
    property p_bank; psw_we |=> program_status_word_q[4:3] == $past(psw_wdata[4:3]); endproperty
    a_bank: assert property (p_bank) else $error("bank bits not loaded");
    property p_dptr; dptr_we |=> data_pointer_pair_q == $past(dptr_wdata); endproperty
    a_dptr: assert property (p_dptr) else $error("pointer not loaded");
    property p_xmove_lat; xmove_req && !x_busy_q |=> s_xwait; endproperty
    a_xmove_lat: assert property (p_xmove_lat) else $error("external latency wrong");
    property p_pstore; pstore_req && !p_busy_q |=> s_pread; endproperty
    a_pstore: assert property (p_pstore) else $error("table read timing wrong");
endmodule : cdm_properties
bind cdm_data_memory cdm_properties u_props (.*);
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the data memory map
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk = '0, rstn = '0, internal_data_ram_req = '0, internal_data_ram_we = '0, psw_we = '0;
    logic        xmove_req = '0, xmove_we = '0, dptr_we = '0, pstore_req = '0;
    logic        internal_data_ram_valid_q, sfr_req_q, sfr_we_q, xmove_ready_q, pstore_rd_q, pstore_ready_q;
    logic [1:0]  internal_data_ram_mode = '0;
    logic [7:0]  internal_data_ram_addr = '0, internal_data_ram_wdata = '0, sfr_rdata = 8'h00, psw_wdata = '0;
    logic [7:0]  xmove_wdata = '0, pstore_data, internal_data_ram_rdata_q, sfr_addr_q, sfr_wdata_q, rd;
    logic [7:0]  program_status_word_q, xmove_rdata_q, pstore_rdata_q;
    logic [12:0] pstore_addr_q;
    logic [15:0] dptr_wdata = '0, data_pointer_pair_q;
    int          miscompares = 0, samples_checked = 0, cycles = 0, n;
    cdm_data_memory dut (.*);
    cdm_store_model u_store (.addr(pstore_addr_q), .rd(pstore_rd_q), .data(pstore_data));
    always #5 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    // one internal access; modes 0 direct 1 indirect 2 bit 3 work reg
    task automatic acc(input logic w, input logic [1:0] m, input logic [7:0] a, input logic [7:0] d);
        internal_data_ram_we = w;
        internal_data_ram_mode = m;
        internal_data_ram_addr = a;
        internal_data_ram_wdata = d;
        internal_data_ram_req = 1'b1;
        step();
        rd = internal_data_ram_rdata_q;
    endtask : acc
    task automatic setpsw(input logic [7:0] v);
        internal_data_ram_req = 1'b0;
        psw_wdata = v;
        psw_we = 1'b1;
        step();
        psw_we = 1'b0;
    endtask : setpsw
    task automatic setptr(input logic [15:0] v);
        internal_data_ram_req = 1'b0;
        dptr_wdata = v;
        dptr_we = 1'b1;
        step();
        dptr_we = 1'b0;
    endtask : setptr
    task automatic xmv(input logic w, input logic [7:0] d);
        xmove_we = w;
        xmove_wdata = d;
        xmove_req = 1'b1;
        step();
        xmove_req = 1'b0;
        for (n = 0; xmove_ready_q !== 1'b1 && n < 20; n++) step();
        chk(n, 3);
    endtask : xmv
    // lower half both ways, upper half split
    task automatic t_map();
        acc(1, 0, 8'h45, 8'hA5);
        acc(0, 1, 8'h45, 8'h00);
        chk(rd, 8'hA5);
        acc(1, 1, 8'h90, 8'h3C);
        acc(1, 0, 8'h90, 8'hC3);
        chk(sfr_wdata_q, 8'hC3);
        chk(sfr_we_q, 1'b1);
        chk(sfr_addr_q, 8'h90);
        acc(0, 1, 8'h90, 8'h00);
        chk(rd, 8'h3C);
    endtask : t_map
    // register 5 in every bank
    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            setpsw(8'(b << 3));
            acc(1, 3, 8'h05, 8'(8'h10 + b));
        end
        chk(program_status_word_q[4:3], 2'h3);
        for (int b = 0; b < 4; b++) begin
            acc(0, 0, 8'(8 * b + 5), 8'h00);
            chk(rd, 8'(8'h10 + b));
        end
        acc(0, 3, 8'h05, 8'h00);
        chk(rd, 8'h13);
    endtask : t_banks
    // single bits set and cleared
    task automatic t_bits();
        acc(1, 0, 8'h28, 8'h00);
        acc(1, 2, 8'h42, 8'h01);
        acc(0, 0, 8'h28, 8'h00);
        chk(rd, 8'h04);
        acc(1, 0, 8'h2F, 8'hFF);
        acc(1, 2, 8'h7F, 8'h00);
        acc(0, 1, 8'h2F, 8'h00);
        chk(rd, 8'h7F);
        acc(0, 2, 8'h78, 8'h00);
        chk(rd[0], 1'b1);
    endtask : t_bits
    // external ram kept apart from internal ram
    task automatic t_external_data_ram();
        setptr(16'h0033);
        xmv(1, 8'h5A);
        acc(1, 1, 8'h33, 8'hEE);
        internal_data_ram_req = 1'b0;
        xmv(0, 8'h00);
        chk(xmove_rdata_q, 8'h5A);
        acc(0, 1, 8'h33, 8'h00);
        chk(rd, 8'hEE);
    endtask : t_external_data_ram
    // slow table read through the pointer
    task automatic t_pstore();
        setptr(16'h1ABC);
        pstore_req = 1'b1;
        step();
        pstore_req = 1'b0;
        for (n = 0; pstore_ready_q !== 1'b1 && n < 30; n++) step();
        chk(n, 13);
        chk(pstore_rdata_q, 8'hCC);
    endtask : t_pstore
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_map();
        t_banks();
        t_bits();
        t_external_data_ram();
        t_pstore();
        final_report();
    end
endmodule : tb_top
`default_nettype wire
